// ### sst_cfg.svh
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

// Register indices on the serial register port.
`define SST_ADDR_DCR 6'h01
`define SST_ADDR_STS 6'h02
`define SST_ADDR_SELF_TEST_STATUS 6'h03
`define SST_ADDR_DIAG 6'h04
`define SST_ADDR_XCST 6'h05
`define SST_ADDR_DATA0 6'h06
`define SST_ADDR_DATA1 6'h07
`define SST_ADDR_TAG 6'h10

// Direct command codes in the low half of a command write.
`define SST_CMD_EOP 16'h00A5
`define SST_CMD_SELFTEST 16'h005A
`define SST_CMD_SWRST 16'h0F0F
`define SST_CMD_ON1 16'h0011
`define SST_CMD_OFF1 16'h0010
`define SST_CMD_ON2 16'h0021
`define SST_CMD_OFF2 16'h0020
`define SST_CMD_AUXON 16'h0031
`define SST_CMD_AUXOFF 16'h0030

// Self-test setting fields and reset value.
`define SST_STS_RESET 16'h0000
`define SST_STS_START 0
`define SST_STS_MASTER 1
`define SST_STS_ABORT 2
`define SST_STS_SEL_LO 5
`define SST_STS_SEL_HI 9
`define SST_STS_LEVEL 10
`define SST_STS_TAGEN 11
`define SST_SEL_OUT1 5'h15
`define SST_SEL_OUT2 5'h16

// Self-test status fields.
`define SST_SELF_TEST_STATUS_BETEST 0
`define SST_SELF_TEST_STATUS_CRC 1
`define SST_SELF_TEST_STATUS_TAG 2

// Buffer empty code.
`define SST_EMPTY_CODE 16'h01F0

// Timing.
`define SST_CLK_NS 10
`define SST_US_NS 1000
`define SST_US_CYCLES (`SST_US_NS / `SST_CLK_NS)
`define SST_LONG_US 512
`define SST_SHORT_US 128

`endif

// ### sst_pkg.sv
package sst_pkg;

   // One request from the serial register port decoder.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [31:0] wdata;
   } sst_req_s;

   // One decoded sensor word from the Manchester decoder.
   typedef struct packed {
      logic valid;
      logic chan;
      logic [2:0] slot;
      logic crcErr;
      logic [15:0] word;
   } sst_dec_s;

   // Analog comparator levels, per line where paired.
   typedef struct packed {
      logic [1:0] uv;
      logic [1:0] stb;
      logic [1:0] ground_short;
      logic auxUv;
   } sst_ana_s;

   // One buffered data word.
   typedef struct packed {
      logic crcErr;
      logic [4:0] tag;
      logic [15:0] word;
   } sst_buf_s;

   typedef enum logic [3:0] {
      XC_IDLE,
      XC_SLV_SINK,
      XC_STB_ON,
      XC_STB_SINK,
      XC_PH1_ON,
      XC_PH1_SINK,
      XC_PH2_ON,
      XC_PH2_SINK
   } sst_xc_e;

endpackage

// ### sst_us_tick.sv
`timescale 1ns/10ps
// Divides the system clock down to a one-cycle tick each microsecond.
module sst_us_tick #(
   parameter int unsigned DIV = 100
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Tick.
   output logic tick
);
   logic [15:0] count_q;

   // Counts DIV cycles and pulses once per wrap.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_q <= 16'h0000;
         tick <= 1'b0;
      end
      else if (count_q == 16'(DIV - 1))
      begin
         count_q <= 16'h0000;
         tick <= 1'b1;
      end
      else
      begin
         count_q <= count_q + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// ### sst_selftest.sv
`timescale 1ns/10ps
`include "sst_cfg.svh"

// How it works
// - Each channel and slot holds a 5-bit tag returned with that slot's data.
// - With tagging on, data frames carry a summary fault bit for aux or parity faults.
// - Tag and decoded word enter the data buffer in one write, slot from the decoder word.
// - After self-test entry, test bits force CRC and tag mismatches.
// - After each data read, empty code is written and checked; mismatch latches fault.
// - Buffer test bit keeps old data on read, so the fault is raised.
// - Test level bit drives the selected data output statically high or low.
// - Select pattern 10101 tests output 1, 10110 output 2, anything else none.
// - At most one data output is ever in test mode.
// - Start accepted only with both lines off; otherwise refused and results cleared.
// - During a running test, line-on and aux-disable commands are ignored.
// - Only the abort bit or a reset stops a test early; aborted flag only in master mode.
// - Running flag high only during a test; done flag raised at its end.
// - Done, aborted and result flags clear on read or on any start request.
// - Ground-short status bits show test results after a master test until cleared.
// - Slave mode sinks both lines 512 us, then passes each line showing no undervoltage.
// - Master battery-short phase per channel: 512 us on, check, 128 us sink.
// - Phase 1 with line 1 alone: ground-short and line 2 coupling checks.
// - Phase 2 mirrors phase 1 for line 2 alone, setting line 1 coupling result.
// - Master test ends by itself after its timed phases.
// - Undervoltage shows only while its line is on, debounced, in real time.
// - Any reset turns lines off; afterwards faults clear and lines stay off.
// - Configuration and self-test entry accepted only before end of programming.
module sst_selftest #(
   parameter int unsigned US_DIV = `SST_US_CYCLES,
   parameter int unsigned LONG_US = `SST_LONG_US,
   parameter int unsigned SHORT_US = `SST_SHORT_US
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port requests and read answer.
   input sst_pkg::sst_req_s req,
   output logic [31:0] rdData,
   output logic rdValid,
   // Decoder words and decoded data outputs.
   input sst_pkg::sst_dec_s dec,
   input wire logic [1:0] decOut,
   output logic [1:0] dataOut,
   output logic crcForce,
   // Analog monitors and other fault sources.
   input sst_pkg::sst_ana_s ana,
   input wire logic parityFault,
   // Supply line controls.
   output logic [1:0] lineEnable,
   output logic [1:0] dischargeSink,
   output logic faultMask,
   output logic auxEnable
);
   import sst_pkg::*;

   logic softRst_q;
   logic rstAll;
   sst_ana_s sync1_q, sync2_q, sync3_q, filt_q;
   logic [15:0] sts_q;
   logic [2:0] self_test_status_q;
   logic selfTest_q, eop_q;
   logic [4:0] tagTable [16];
   sst_buf_s buf_q [2];
   logic [1:0] checkPend_q, beFault_q;
   sst_xc_e state_q;
   logic master_q, stbCh_q, stgHold_q, doneFlag_q, abortFlag_q;
   logic [1:0] excl_q, chRes_q, stbRes_q, stgRes_q;
   logic [9:0] timer_q;
   logic usTick, timerEnd;
   logic dcrWr, startReq, abortReq, xcRead, diagRead, running;
   logic [1:0] dataRead;
   logic [15:0] cmd;
   logic [4:0] outSel;
   logic [31:0] rdNext;

   // Soft reset joins the port reset for everything but itself.
   assign rstAll = rst | softRst_q;
   assign dcrWr = req.wr && req.addr == `SST_ADDR_DCR;
   assign cmd = req.wdata[15:0];
   assign startReq = req.wr && req.addr == `SST_ADDR_STS && req.wdata[`SST_STS_START];
   assign abortReq = req.wr && req.addr == `SST_ADDR_STS && req.wdata[`SST_STS_ABORT];
   assign xcRead = req.rd && req.addr == `SST_ADDR_XCST;
   assign diagRead = req.rd && req.addr == `SST_ADDR_DIAG;
   assign dataRead[0] = req.rd && req.addr == `SST_ADDR_DATA0;
   assign dataRead[1] = req.rd && req.addr == `SST_ADDR_DATA1;
   assign running = state_q != XC_IDLE;
   assign timerEnd = timer_q == 10'h000;
   assign outSel = sts_q[`SST_STS_SEL_HI:`SST_STS_SEL_LO];

   // Microsecond time base for every phase of the coupling test.
   sst_us_tick #(
      .DIV(US_DIV)
   ) u_tick (
      .clk(clk),
      .rst(rstAll),
      .tick(usTick)
   );

   // Builds the frame returned for a data read of one channel.
   function automatic logic [31:0] dataFrame(input sst_buf_s b, input logic tagOn,
                                             input logic gFault);
      dataFrame = {tagOn & gFault, b.crcErr, 9'h000, b.tag, b.word};
   endfunction

   // Self-clearing soft reset command.
   always_ff @(posedge clk)
   begin
      if (rst)
         softRst_q <= 1'b0;
      else
         softRst_q <= dcrWr && cmd == `SST_CMD_SWRST;
   end

   // Two-flop synchronisers, then a filter that follows two agreeing samples.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         filt_q <= '0;
      end
      else
      begin
         sync1_q <= ana;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q)
            filt_q <= sync2_q;
      end
   end

   // Configuration, self-test entry and end of programming.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         sts_q <= `SST_STS_RESET;
         self_test_status_q <= 3'b000;
         selfTest_q <= 1'b0;
         eop_q <= 1'b0;
      end
      else if (req.wr)
      begin
         if (dcrWr && cmd == `SST_CMD_EOP)
            eop_q <= 1'b1;
         if (dcrWr && cmd == `SST_CMD_SELFTEST && !eop_q)
            selfTest_q <= 1'b1;
         if (req.addr == `SST_ADDR_STS && !eop_q)
            sts_q <= req.wdata[15:0];
         if (req.addr == `SST_ADDR_SELF_TEST_STATUS)
            self_test_status_q <= req.wdata[2:0];
      end
   end

   // Slot tag table, two channels of eight slots, locked after programming.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         for (int i = 0; i < 16; i++)
            tagTable[i] <= 5'h00;
      end
      else if (req.wr && req.addr[5:4] == `SST_ADDR_TAG >> 4 && !eop_q)
         tagTable[req.addr[3:0]] <= req.wdata[4:0];
   end

   // Data buffers: decoder fills, reads empty them.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         for (int c = 0; c < 2; c++)
            buf_q[c] <= '{crcErr: 1'b0, tag: 5'h00, word: `SST_EMPTY_CODE};
         checkPend_q <= 2'b00;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            checkPend_q[c] <= 1'b0;
            if (dec.valid && dec.chan == 1'(c))
            begin
               // Tag and word land together; self-test may corrupt either check.
               buf_q[c] <= '{
                  crcErr: dec.crcErr | (selfTest_q & self_test_status_q[`SST_SELF_TEST_STATUS_CRC]),
                  tag: tagTable[{dec.chan, dec.slot}]
                       ^ {5{selfTest_q & self_test_status_q[`SST_SELF_TEST_STATUS_TAG]}},
                  word: dec.word};
            end
            else if (dataRead[c])
            begin
               if (!self_test_status_q[`SST_SELF_TEST_STATUS_BETEST])
                  buf_q[c].word <= `SST_EMPTY_CODE;
               checkPend_q[c] <= 1'b1;
            end
         end
      end
   end

   // Empty check one cycle after a read; fault clears on diagnostic register read, set wins.
   always_ff @(posedge clk)
   begin
      if (rstAll)
         beFault_q <= 2'b00;
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (checkPend_q[c] && buf_q[c].word != `SST_EMPTY_CODE)
               beFault_q[c] <= 1'b1;
            else if (diagRead)
               beFault_q[c] <= 1'b0;
         end
      end
   end

   // Data outputs: select decode allows one channel under test at most.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         dataOut <= 2'b00;
         crcForce <= 1'b0;
      end
      else
      begin
         dataOut[0] <= outSel == `SST_SEL_OUT1 ? sts_q[`SST_STS_LEVEL] : decOut[0];
         dataOut[1] <= outSel == `SST_SEL_OUT2 ? sts_q[`SST_STS_LEVEL] : decOut[1];
         crcForce <= selfTest_q & self_test_status_q[`SST_SELF_TEST_STATUS_CRC];
      end
   end

   // Phase timer counting microsecond ticks down to zero.
   always_ff @(posedge clk)
   begin
      if (rstAll)
         timer_q <= 10'h000;
      else if (!running && startReq && lineEnable == 2'b00)
         timer_q <= 10'(LONG_US);
      else if (running && timerEnd)
      begin
         unique case (state_q)
            XC_STB_ON, XC_PH1_ON, XC_PH2_ON:
               timer_q <= 10'(SHORT_US);
            default:
               timer_q <= 10'(LONG_US);
         endcase
      end
      else if (usTick && !timerEnd)
         timer_q <= timer_q - 10'h001;
   end

   // Coupling test sequencer, which also owns the supply line controls.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         state_q <= XC_IDLE;
         lineEnable <= 2'b00;
         dischargeSink <= 2'b00;
         faultMask <= 1'b0;
         auxEnable <= 1'b1;
         master_q <= 1'b0;
         stbCh_q <= 1'b0;
         excl_q <= 2'b00;
      end
      else if (!running)
      begin
         if (startReq && lineEnable == 2'b00)
         begin
            master_q <= req.wdata[`SST_STS_MASTER];
            excl_q <= 2'b00;
            stbCh_q <= 1'b0;
            if (req.wdata[`SST_STS_MASTER])
            begin
               state_q <= XC_STB_ON;
               lineEnable <= 2'b01;
               faultMask <= 1'b1;
            end
            else
            begin
               state_q <= XC_SLV_SINK;
               dischargeSink <= 2'b11;
            end
         end
         else if (dcrWr)
         begin
            if (cmd == `SST_CMD_ON1)
               lineEnable[0] <= 1'b1;
            if (cmd == `SST_CMD_OFF1)
               lineEnable[0] <= 1'b0;
            if (cmd == `SST_CMD_ON2)
               lineEnable[1] <= 1'b1;
            if (cmd == `SST_CMD_OFF2)
               lineEnable[1] <= 1'b0;
            if (cmd == `SST_CMD_AUXON)
               auxEnable <= 1'b1;
            if (cmd == `SST_CMD_AUXOFF)
               auxEnable <= 1'b0;
         end
      end
      else if (abortReq)
      begin
         // Abort stops a running test before its timed phases end; line and aux commands are ignored while it runs.
         state_q <= XC_IDLE;
         lineEnable <= 2'b00;
         dischargeSink <= 2'b00;
         faultMask <= 1'b0;
      end
      else if (timerEnd)
      begin
         unique case (state_q)
            XC_SLV_SINK:
            begin
               dischargeSink <= 2'b00;
               state_q <= XC_IDLE;
            end
            XC_STB_ON:
            begin
               if (filt_q.stb[stbCh_q])
                  excl_q[stbCh_q] <= 1'b1;
               lineEnable <= 2'b00;
               dischargeSink[stbCh_q] <= 1'b1;
               state_q <= XC_STB_SINK;
            end
            XC_STB_SINK:
            begin
               dischargeSink <= 2'b00;
               if (!stbCh_q)
               begin
                  stbCh_q <= 1'b1;
                  lineEnable <= 2'b10;
                  state_q <= XC_STB_ON;
               end
               else if (!excl_q[0])
               begin
                  lineEnable <= 2'b01;
                  state_q <= XC_PH1_ON;
               end
               else if (!excl_q[1])
               begin
                  lineEnable <= 2'b10;
                  state_q <= XC_PH2_ON;
               end
               else
               begin
                  faultMask <= 1'b0;
                  state_q <= XC_IDLE;
               end
            end
            XC_PH1_ON:
            begin
               lineEnable <= 2'b00;
               dischargeSink <= 2'b01;
               state_q <= XC_PH1_SINK;
            end
            XC_PH1_SINK:
            begin
               dischargeSink <= 2'b00;
               if (!excl_q[1])
               begin
                  lineEnable <= 2'b10;
                  state_q <= XC_PH2_ON;
               end
               else
               begin
                  faultMask <= 1'b0;
                  state_q <= XC_IDLE;
               end
            end
            XC_PH2_ON:
            begin
               lineEnable <= 2'b00;
               dischargeSink <= 2'b10;
               state_q <= XC_PH2_SINK;
            end
            XC_PH2_SINK:
            begin
               dischargeSink <= 2'b00;
               faultMask <= 1'b0;
               state_q <= XC_IDLE;
            end
            XC_IDLE:
               state_q <= XC_IDLE;
         endcase
      end
   end

   // Test results: cleared by read or any start request, but a set in the same cycle wins.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         doneFlag_q <= 1'b0;
         abortFlag_q <= 1'b0;
         chRes_q <= 2'b00;
         stbRes_q <= 2'b00;
         stgRes_q <= 2'b00;
         stgHold_q <= 1'b0;
      end
      else
      begin
         if (xcRead || startReq)
         begin
            doneFlag_q <= 1'b0;
            abortFlag_q <= 1'b0;
            chRes_q <= 2'b00;
            stbRes_q <= 2'b00;
            stgRes_q <= 2'b00;
            stgHold_q <= 1'b0;
         end
         if (running && abortReq)
            abortFlag_q <= master_q;
         else if (running && timerEnd)
         begin
            unique case (state_q)
               XC_SLV_SINK:
               begin
                  chRes_q <= ~filt_q.uv;
                  doneFlag_q <= 1'b1;
               end
               XC_STB_ON:
                  stbRes_q[stbCh_q] <= filt_q.stb[stbCh_q];
               XC_PH1_ON:
               begin
                  stgRes_q[0] <= filt_q.uv[0];
                  chRes_q[1] <= ~filt_q.uv[1];
               end
               XC_PH2_ON:
               begin
                  stgRes_q[1] <= filt_q.uv[1];
                  chRes_q[0] <= ~filt_q.uv[0];
               end
               XC_STB_SINK, XC_PH1_SINK, XC_PH2_SINK:
               begin
                  // Master sequence is over once no further phase will run.
                  if ((state_q == XC_STB_SINK && stbCh_q && excl_q == 2'b11)
                      || (state_q == XC_PH1_SINK && excl_q[1])
                      || state_q == XC_PH2_SINK)
                  begin
                     doneFlag_q <= 1'b1;
                     stgHold_q <= 1'b1;
                  end
               end
               XC_IDLE:
                  doneFlag_q <= doneFlag_q;
            endcase
         end
      end
   end

   // Read data mux for the register port.
   always_comb
   begin
      rdNext = 32'h0000_0000;
      unique case (req.addr)
         `SST_ADDR_STS:
            rdNext = {16'h0000, sts_q};
         `SST_ADDR_SELF_TEST_STATUS:
            rdNext = {29'h0000_0000, self_test_status_q};
         `SST_ADDR_DIAG:
         begin
            // Ground-short bits follow the line until a master test result is held.
            rdNext[0] = stgHold_q ? stgRes_q[0] : filt_q.ground_short[0] & lineEnable[0];
            rdNext[8] = stgHold_q ? stgRes_q[1] : filt_q.ground_short[1] & lineEnable[1];
            rdNext[1] = filt_q.uv[0] & lineEnable[0];
            rdNext[9] = filt_q.uv[1] & lineEnable[1];
            rdNext[2] = beFault_q[0];
            rdNext[10] = beFault_q[1];
            rdNext[3] = stbRes_q[0];
            rdNext[11] = stbRes_q[1];
         end
         `SST_ADDR_XCST:
            rdNext = {25'h0000000, stbRes_q, chRes_q, abortFlag_q, doneFlag_q, running};
         `SST_ADDR_DATA0:
            rdNext = dataFrame(buf_q[0], sts_q[`SST_STS_TAGEN], filt_q.auxUv | parityFault);
         `SST_ADDR_DATA1:
            rdNext = dataFrame(buf_q[1], sts_q[`SST_STS_TAGEN], filt_q.auxUv | parityFault);
         default:
            rdNext = 32'h0000_0000;
      endcase
   end

   // Registered read answer, one cycle after the request.
   always_ff @(posedge clk)
   begin
      if (rstAll)
      begin
         rdData <= 32'h0000_0000;
         rdValid <= 1'b0;
      end
      else
      begin
         rdValid <= req.rd;
         if (req.rd)
            rdData <= rdNext;
      end
   end
endmodule

// ### sst_selftest_sva.sv
`timescale 1ns/10ps
`include "sst_cfg.svh"
// Watches the register port answers and the supply line controls.
module sst_selftest_sva
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire sst_pkg::sst_req_s req,
   input wire logic rdValid,
   // Supply line controls.
   input wire logic [1:0] lineEnable,
   input wire logic [1:0] dischargeSink,
   input wire logic faultMask,
   input wire logic auxEnable
);
   import sst_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // A start write, an idle block and a command write, used by the properties below.
   sequence sStart(logic m);
      req.wr && req.addr == `SST_ADDR_STS && req.wdata[0] && !req.wdata[2] && req.wdata[1] == m;
   endsequence
   sequence sIdle;
      lineEnable == 2'h0 && dischargeSink == 2'h0 && !faultMask;
   endsequence
   sequence sCmd(logic [15:0] c);
      req.wr && req.addr == `SST_ADDR_DCR && req.wdata[15:0] == c;
   endsequence

   a_read_answer: assert property (req.rd |=> rdValid)
      else $error("read not answered in the next cycle");
   a_valid_cause: assert property (rdValid |-> $past(req.rd))
      else $error("read answer without a read");
   a_reset_off: assert property (disable iff (1'b0) rst |=> lineEnable == 2'h0 && auxEnable)
      else $error("lines not off after reset");
   a_soft_reset: assert property (sCmd(`SST_CMD_SWRST) |-> ##[1:3] lineEnable == 2'h0)
      else $error("soft reset left a line on");
   a_slave_sinks: assert property (sStart(1'b0) ##0 sIdle |=> dischargeSink == 2'h3)
      else $error("slave start did not sink both lines");
   a_master_first: assert property (sStart(1'b1) ##0 sIdle |=> faultMask && lineEnable == 2'h1)
      else $error("master start did not enable line one alone");
   a_start_refused: assert property (sStart(1'b0) ##0 (lineEnable != 2'h0 && !faultMask)
      |=> dischargeSink == 2'h0)
      else $error("start accepted with a line on");
   a_sink_apart: assert property ((dischargeSink & lineEnable) == 2'h0)
      else $error("sink on a line that is on");
   a_one_line: assert property (faultMask |-> lineEnable != 2'h3)
      else $error("both lines on during master test");
   a_on_ignored: assert property (dischargeSink == 2'h3 ##0 (sCmd(`SST_CMD_ON1) or sCmd(`SST_CMD_ON2))
      |=> (lineEnable == 2'h0) [*2])
      else $error("line switched on during test");
   a_aux_kept: assert property (dischargeSink == 2'h3 && auxEnable ##0 sCmd(`SST_CMD_AUXOFF)
      |=> auxEnable [*2])
      else $error("aux regulator disabled during test");
endmodule

bind sst_selftest sst_selftest_sva chk (.clk(clk), .rst(rst), .req(req), .rdValid(rdValid),
   .lineEnable(lineEnable), .dischargeSink(dischargeSink), .faultMask(faultMask),
   .auxEnable(auxEnable));

// ### sst_mcu_model.sv
`timescale 1ns/10ps
// Microcontroller side of the register port, one request at a time.
module sst_mcu_model
(
   // Clock.
   input wire logic clk,
   // Register port.
   output sst_pkg::sst_req_s req,
   input wire logic [31:0] rdData,
   input wire logic rdValid
);
   import sst_pkg::*;
   initial req = '0;

   // Holds a write over the edge that takes it; released lines show inverted values.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 req = '{1'b0, 1'b0, ~a, ~d};
      @(posedge clk);
      #1;
   endtask

   // Holds a read over one edge and takes the answer in the cycle after it.
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      req = '{1'b0, 1'b1, a, ~req.wdata};
      @(posedge clk);
      #1 req = '{1'b0, 1'b0, ~a, req.wdata};
      d = (rdValid === 1'b1) ? rdData : ~rdData;
      @(posedge clk);
      #1;
   endtask
endmodule

// ### sst_selftest_tb.sv
`timescale 1ns/10ps
`include "sst_cfg.svh"
module sst_selftest_tb;
   import sst_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic parityFault = 1'b0;
   logic [1:0] decOut = 2'h0;
   sst_dec_s dec = '0;
   sst_ana_s ana = '0;
   sst_req_s req;
   logic [31:0] rdData, got, frame;
   logic rdValid, crcForce, faultMask, auxEnable;
   logic [1:0] dataOut, lineEnable, dischargeSink, e;
   logic [15:0] lfsr = 16'hDBA5;
   logic [4:0] sels[6] = '{5'h15, 5'h16, 5'h14, 5'h17, 5'h05, 5'h1F};
   int failCount = 0;
   int testsRun = 0;
   int cyc = 0;
   int n;
   int tagMem[16];

   // Clock and hang limit.
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failCount++;
         closeOut();
      end
   end

   sst_selftest #(.US_DIV(4), .LONG_US(8), .SHORT_US(2)) DUT (.clk(clk), .rst(rst), .req(req),
      .rdData(rdData), .rdValid(rdValid), .dec(dec), .decOut(decOut), .dataOut(dataOut),
      .crcForce(crcForce), .ana(ana), .parityFault(parityFault), .lineEnable(lineEnable),
      .dischargeSink(dischargeSink), .faultMask(faultMask), .auxEnable(auxEnable));
   sst_mcu_model mcu (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid));

   // Pseudo-random source, comparison, waits and the closing report.
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      testsRun++;
      if (g !== x)
      begin
         failCount++;
         $display("BAD t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic c, input logic [2:0] s, input logic [15:0] w);
      dec = '{1'b1, c, s, 1'b0, w};
      @(posedge clk);
      #1 dec = '{1'b0, ~c, ~s, 1'b1, ~w};
   endtask
   task automatic xcWait();
      n = 0;
      while ((faultMask || dischargeSink != 2'h0) && n < 400)
      begin
         tick(1);
         n++;
      end
      mcu.rd(`SST_ADDR_DIAG, frame);
      mcu.rd(`SST_ADDR_XCST, got);
   endtask
   task automatic closeOut();
      if (failCount == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence: data path, self-test hooks, output test, coupling tests, lock.
   initial
   begin
      tick(6);
      rst = 1'b0;
      chk(32'h4, {29'h0, auxEnable, lineEnable});
      for (int i = 0; i < 16; i++)
      begin
         lfsr = nxt(lfsr);
         tagMem[i] = lfsr[4:0];
         mcu.wr(`SST_ADDR_TAG + 6'(i), 32'(lfsr[4:0]));
      end
      mcu.wr(`SST_ADDR_STS, 32'h800);
      for (int c = 0; c < 2; c++)
      begin
         lfsr = nxt(lfsr);
         parityFault = c[0];
         send(c[0], lfsr[2:0], lfsr);
         mcu.rd(`SST_ADDR_DATA0 + 6'(c), got);
         chk({c[0], 10'h0, 5'(tagMem[c * 8 + lfsr[2:0]]), lfsr}, got);
         mcu.rd(`SST_ADDR_DATA0 + 6'(c), got);
         chk(32'h1F0, {16'h0, got[15:0]});
      end
      parityFault = 1'b0;
      mcu.rd(`SST_ADDR_DIAG, got);
      chk(32'h0, {30'h0, got[10], got[2]});
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_SELFTEST));
      mcu.wr(`SST_ADDR_SELF_TEST_STATUS, 32'h3);
      chk(32'h1, {31'h0, crcForce});
      send(1'b0, 3'h2, 16'h0ABC);
      mcu.rd(`SST_ADDR_DATA0, frame);
      chk({2'h1, 9'h0, 5'(tagMem[2]), 16'h0ABC}, frame);
      mcu.rd(`SST_ADDR_DATA0, got);
      chk(frame, got);
      tick(2);
      mcu.rd(`SST_ADDR_DIAG, got);
      chk(32'h1, {31'h0, got[2]});
      mcu.rd(`SST_ADDR_DIAG, got);
      chk(32'h0, {31'h0, got[2]});
      mcu.wr(`SST_ADDR_SELF_TEST_STATUS, 32'h4);
      send(1'b0, 3'h2, 16'h0123);
      mcu.rd(`SST_ADDR_DATA0, got);
      chk({27'h0, ~5'(tagMem[2])}, {27'h0, got[20:16]});
      mcu.wr(`SST_ADDR_SELF_TEST_STATUS, 32'h0);
      for (int k = 0; k < 6; k++)
      begin
         lfsr = nxt(lfsr);
         decOut = lfsr[1:0];
         mcu.wr(`SST_ADDR_STS, {21'h0, lfsr[2], sels[k], 5'h0});
         e = decOut;
         if (sels[k] == `SST_SEL_OUT1) e[0] = lfsr[2];
         if (sels[k] == `SST_SEL_OUT2) e[1] = lfsr[2];
         chk({30'h0, e}, {30'h0, dataOut});
      end
      mcu.wr(`SST_ADDR_STS, 32'h0);
      ana.uv = 2'h3;
      mcu.rd(`SST_ADDR_DIAG, got);
      chk(32'h0, {30'h0, got[9], got[1]});
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_ON1));
      tick(6);
      mcu.rd(`SST_ADDR_DIAG, got);
      chk(32'h1, {30'h0, got[9], got[1]});
      mcu.wr(`SST_ADDR_STS, 32'h1);
      mcu.rd(`SST_ADDR_XCST, got);
      chk(32'h0, {23'h0, dischargeSink, got[6:0]});
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_SWRST));
      tick(2);
      chk(32'h0, {30'h0, lineEnable});
      ana.uv = 2'h1;
      mcu.wr(`SST_ADDR_STS, 32'h1);
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_ON2));
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_AUXOFF));
      chk(32'h13, {27'h0, auxEnable, lineEnable, dischargeSink});
      xcWait();
      chk(32'h12, {25'h0, got[6:0]});
      mcu.rd(`SST_ADDR_XCST, got);
      chk(32'h0, {25'h0, got[6:0]});
      for (int m = 0; m < 2; m++)
      begin
         mcu.wr(`SST_ADDR_STS, 32'(1 + 2 * m));
         mcu.wr(`SST_ADDR_STS, 32'h4);
         mcu.rd(`SST_ADDR_XCST, got);
         chk(32'(m * 4), {29'h0, got[2], 1'b0, got[0]});
         tick(12);
      end
      mcu.wr(`SST_ADDR_STS, 32'h3);
      chk(32'h5, {29'h0, faultMask, lineEnable});
      xcWait();
      chk(32'h1, {30'h0, frame[8], frame[0]});
      chk(32'h12, {25'h0, got[6:0]});
      chk(32'h0, {29'h0, faultMask, lineEnable});
      mcu.wr(`SST_ADDR_DCR, 32'(`SST_CMD_EOP));
      decOut = 2'h2;
      mcu.wr(`SST_ADDR_STS, 32'h6A0);
      chk(32'h2, {30'h0, dataOut});
      closeOut();
   end
endmodule
